// ---- cmp_irq_pkg.sv ----
// package: constants and carriers for the counter compare interrupt record
package cmp_irq_pkg;
  localparam int          CHAN_COUNT     = 2;
  localparam int          CHAN_W         = 1;
  localparam int          COUNT_W        = 32;
  localparam logic [15:0] REC_ID_PRIMARY = 16'h0001;
  localparam logic [15:0] REC_ID_ALT     = 16'h0010;
  localparam logic [7:0]  CHAN_NUM_MAX   = 8'h0f;
  localparam logic [7:0]  EVT_CMP_REACHED = 8'h05;

  typedef enum logic [1:0] {
    MODE_COUNT,
    MODE_FREQ,
    MODE_OFF
  } op_mode_t;

  typedef struct packed {
    logic [15:0] ident;
    logic [7:0]  channel;
    logic [7:0]  event_code;
  } irq_record_t;

  typedef struct packed {
    logic signed [COUNT_W-1:0] count;
    logic signed [COUNT_W-1:0] cmp_value;
    logic signed [COUNT_W-1:0] low_limit;
    logic signed [COUNT_W-1:0] high_limit;
    op_mode_t                  mode;
    logic                      irq_enable;
  } chan_cfg_t;
endpackage : cmp_irq_pkg

// ---- cmp_detect.sv ----
// per-channel comparison-reached edge detector
`timescale 1ns/1ps
module cmp_detect
  import cmp_irq_pkg::*;
(
  input  wire logic      clk_sys_i,
  input  wire logic      sys_rst_i,
  input  wire chan_cfg_t cfg_i,
  output logic           hit_o
);
  typedef struct packed {
    logic reached;
  } det_state_t;

  det_state_t st;
  det_state_t next_st;
  logic       in_limits;
  logic       reached_now;

  always_comb begin
    // compare value outside the limits can never be reached
    in_limits   = (cfg_i.cmp_value >= cfg_i.low_limit) &&
                  (cfg_i.cmp_value <= cfg_i.high_limit);
    reached_now = in_limits && (cfg_i.count == cfg_i.cmp_value);
    next_st.reached = reached_now;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // only the arrival at the value counts, not dwelling on it
  assign hit_o = next_st.reached && !st.reached && (cfg_i.mode == MODE_COUNT)
                 && cfg_i.irq_enable;
endmodule : cmp_detect

// ---- cmp_irq_record.sv ----
// counter compare hardware interrupt with additional information record
//
// Behaviour
// - only a channel's comparison-reached event raises the interrupt.
// - the record begins with a two-byte identifier 0x0001 or 0x0010.
// - the record carries the triggering channel number, 0x00 to 0x0f.
// - the record carries event code 0x05 for comparison reached.
// - the interrupt fires only while the channel is in counting mode; mode gates only the hit, not a queued event.
// - reaching a compare value within the limits triggers the parameterized reaction.
// - count limits are inputs that may change at any time without restart.
// - a per-channel enable locks or activates the comparison interrupt.
`timescale 1ns/1ps
module cmp_irq_record
  import cmp_irq_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   sys_rst_i,
  input  wire chan_cfg_t [CHAN_COUNT-1:0] cfg_i,
  input  wire logic                   id_alt_i,
  input  wire logic                   fetch_i,
  output logic                        irq_o,
  output irq_record_t                 record_o,
  output logic [CHAN_COUNT-1:0]       lost_o
);
  // ********************************************************************
  // state
  // ********************************************************************
  typedef enum logic {
    IDLE,
    RAISED
  } irq_state_e_t;

  typedef struct packed {
    irq_state_e_t          fsm;
    irq_record_t           rec;
    logic [CHAN_COUNT-1:0] pend;
    logic [CHAN_COUNT-1:0] lost;
  } top_state_t;

  top_state_t            st;
  top_state_t            next_st;
  logic [CHAN_COUNT-1:0] hit;
  logic [CHAN_COUNT-1:0] pend_all;
  logic                  sel_found;
  logic [CHAN_W-1:0]     sel;

  // ********************************************************************
  // per-channel detection
  // ********************************************************************
  for (genvar g = 0; g < CHAN_COUNT; g++) begin : g_chan
    cmp_detect cmp_detect_inst (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .cfg_i     (cfg_i[g]),
      .hit_o     (hit[g])
    );
  end

  // ********************************************************************
  // record build and hold
  // ********************************************************************
  always_comb begin
    next_st   = st;
    pend_all  = st.pend | hit;
    sel_found = 1'b0;
    sel       = '0;
    // lowest channel wins; others wait in pend
    for (int i = CHAN_COUNT - 1; i >= 0; i--) begin
      if (pend_all[i]) begin
        sel_found = 1'b1;
        sel       = CHAN_W'(i);
      end
    end
    next_st.pend = pend_all;
    // a second hit on a pending channel folds into one request unless IDLE serves that channel in the same cycle
    next_st.lost = st.lost | (st.pend & hit);
    case (st.fsm)
      IDLE: begin
        if (sel_found) begin
          next_st.fsm            = RAISED;
          next_st.rec.ident      = id_alt_i ? REC_ID_ALT : REC_ID_PRIMARY;
          next_st.rec.channel    = 8'(sel);
          next_st.rec.event_code = EVT_CMP_REACHED;
          next_st.pend[sel]      = hit[sel] & st.pend[sel];
        end
      end
      RAISED: begin
        if (fetch_i) begin
          next_st.fsm = IDLE;
        end
      end
      default: begin
        next_st.fsm = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '{fsm: IDLE, rec: '0, pend: '0, lost: '0};
    end else begin
      st <= next_st;
    end
  end

  assign irq_o    = (st.fsm == RAISED);
  assign record_o = st.rec;
  assign lost_o   = st.lost;

  // ********************************************************************
  // assertions
  // ********************************************************************
  sequence s_raise;
    !irq_o ##1 irq_o;
  endsequence

  sequence s_fetched;
    irq_o && fetch_i;
  endsequence

  property p_only_on_hit;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      s_raise |-> $past(pend_all != '0);
  endproperty
  a_only_on_hit: assert property (p_only_on_hit) else $error("irq without event");

  property p_quiet;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (!irq_o && pend_all == '0) |=> !irq_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq with nothing pending");

  property p_raise_next;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (!irq_o && pend_all != '0) |=> irq_o;
  endproperty
  a_raise_next: assert property (p_raise_next) else $error("pending event not raised");

  property p_ident_sel;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      s_raise |-> record_o.ident == ($past(id_alt_i) ? REC_ID_ALT : REC_ID_PRIMARY);
  endproperty
  a_ident_sel: assert property (p_ident_sel) else $error("wrong identifier chosen");

  property p_ident;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      irq_o |-> (record_o.ident == REC_ID_PRIMARY || record_o.ident == REC_ID_ALT);
  endproperty
  a_ident: assert property (p_ident) else $error("bad record identifier");

  property p_chan;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      irq_o |-> (record_o.channel <= CHAN_NUM_MAX) && (record_o.channel < CHAN_COUNT);
  endproperty
  a_chan: assert property (p_chan) else $error("channel number out of range");

  property p_event;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      irq_o |-> record_o.event_code == EVT_CMP_REACHED;
  endproperty
  a_event: assert property (p_event) else $error("wrong event code");

  property p_hold;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (irq_o && !fetch_i) |=> irq_o && $stable(record_o);
  endproperty
  a_hold: assert property (p_hold) else $error("record changed before fetch");

  property p_release;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      s_fetched |=> !irq_o;
  endproperty
  a_release: assert property (p_release) else $error("irq not dropped on fetch");

  // ********************************************************************
  // per-channel assertions
  // ********************************************************************
  for (genvar g = 0; g < CHAN_COUNT; g++) begin : g_chk
    // channels below g; all clear means g is first in line
    localparam logic [CHAN_COUNT-1:0] LOWER = CHAN_COUNT'((1 << g) - 1);

    property p_mode;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
        hit[g] |-> cfg_i[g].mode == MODE_COUNT && cfg_i[g].irq_enable;
    endproperty
    a_mode: assert property (p_mode) else $error("hit outside counting or locked");

    property p_limits;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
        hit[g] |-> cfg_i[g].cmp_value >= cfg_i[g].low_limit &&
                   cfg_i[g].cmp_value <= cfg_i[g].high_limit &&
                   cfg_i[g].count == cfg_i[g].cmp_value;
    endproperty
    a_limits: assert property (p_limits) else $error("hit off value or limits");

    property p_order;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
        (!irq_o && pend_all[g] && (pend_all & LOWER) == '0) |=>
          irq_o && record_o.channel == 8'(g);
    endproperty
    a_order: assert property (p_order) else $error("wrong channel served");

    property p_pend_keep;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
        (irq_o && st.pend[g]) |=> st.pend[g];
    endproperty
    a_pend_keep: assert property (p_pend_keep) else $error("queued event dropped");

    property p_lost_set;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
        (st.pend[g] && hit[g]) |=> lost_o[g];
    endproperty
    a_lost_set: assert property (p_lost_set) else $error("folded hit not flagged");

    property p_lost_keep;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
        lost_o[g] |=> lost_o[g];
    endproperty
    a_lost_keep: assert property (p_lost_keep) else $error("lost flag cleared");

    property p_lost_cause;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
        $rose(lost_o[g]) |-> $past(st.pend[g] && hit[g]);
    endproperty
    a_lost_cause: assert property (p_lost_cause) else $error("lost flag without cause");
  end
endmodule : cmp_irq_record

// ---- io_ctrl_model.sv ----
// io controller model that fetches interrupt records
`timescale 1ns/1ps
module io_ctrl_model
  import cmp_irq_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        irq_i,
  input  wire irq_record_t record_i,
  input  wire logic        slow_i,
  output logic             fetch_o,
  output irq_record_t      rec_o,
  output logic [7:0]       n_o
);
  logic [4:0] wait_cnt;

  // slow fetch keeps a record pending so later hits queue behind it
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fetch_o  <= 1'b0;
      rec_o    <= '0;
      n_o      <= 8'h0;
      wait_cnt <= 5'h0;
    end else begin
      fetch_o <= 1'b0;
      if (irq_i && fetch_o) begin
        rec_o <= record_i;
        n_o   <= n_o + 8'h1;
      end
      if (irq_i && !fetch_o) begin
        if (wait_cnt >= (slow_i ? 5'h14 : 5'h1)) begin
          fetch_o  <= 1'b1;
          wait_cnt <= 5'h0;
        end else begin
          wait_cnt <= wait_cnt + 5'h1;
        end
      end
    end
  end
endmodule : io_ctrl_model

// ---- cmp_irq_record_tb.sv ----
// self-checking bench for the compare interrupt record
`timescale 1ns/1ps
module cmp_irq_record_tb;
  import cmp_irq_pkg::*;
  logic                       clk_sys_i, sys_rst_i, id_alt, fetch, irq, slow;
  chan_cfg_t [CHAN_COUNT-1:0] cfg;
  irq_record_t                record, rec;
  logic [CHAN_COUNT-1:0]      lost;
  logic [7:0]                 n;
  int                         error_cnt, compares, exp_n;

  cmp_irq_record cmp_irq_record_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .cfg_i(cfg), .id_alt_i(id_alt), .fetch_i(fetch), .irq_o(irq), .record_o(record),
    .lost_o(lost));
  io_ctrl_model io_ctrl_model_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .irq_i(irq), .record_i(record), .slow_i(slow), .fetch_o(fetch), .rec_o(rec), .n_o(n));

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // count sits on the compare value for one cycle, so each call is one hit
  task hit(input logic [1:0] m);
    @(posedge clk_sys_i);
    for (int c = 0; c < CHAN_COUNT; c++) cfg[c].count <= m[c] ? 32'sh5 : 32'sh0;
    @(posedge clk_sys_i);
    for (int c = 0; c < CHAN_COUNT; c++) cfg[c].count <= 32'sh0;
  endtask : hit

  task get(input logic [31:0] e);
    exp_n++;
    for (int i = 0; i < 100 && n < exp_n; i++) @(posedge clk_sys_i);
    chk("fetches", exp_n, 32'(n));
    chk("record", e, rec);
  endtask : get

  task t_basic;
    hit(2'h1);
    get(32'h00010005);
    id_alt <= 1'b1;
    hit(2'h2);
    get(32'h00100105);
    id_alt <= 1'b0;
    $display("test basic done");
  endtask : t_basic

  task t_block;
    cfg[0].mode       <= MODE_FREQ;
    cfg[1].irq_enable <= 1'b0;
    hit(2'h3);
    cfg[0].mode <= MODE_OFF;
    hit(2'h1);
    cfg[0].mode       <= MODE_COUNT;
    cfg[1].irq_enable <= 1'b1;
    cfg[0].high_limit <= 32'sh3;
    hit(2'h1);
    repeat (10) @(posedge clk_sys_i);
    chk("fetches", exp_n, 32'(n));
    chk("irq", 32'h0, 32'(irq));
    cfg[0].high_limit <= 32'sh8;
    hit(2'h1);
    get(32'h00010005);
    $display("test block done");
  endtask : t_block

  task t_queue;
    hit(2'h3);
    get(32'h00010005);
    get(32'h00010105);
    slow <= 1'b1;
    hit(2'h1);
    hit(2'h2);
    hit(2'h2);
    @(posedge clk_sys_i);
    chk("lost", 32'h2, 32'(lost));
    chk("held", 32'h00010005, record);
    get(32'h00010005);
    get(32'h00010105);
    slow <= 1'b0;
    repeat (30) @(posedge clk_sys_i);
    chk("requests", exp_n, 32'(n));
    $display("test queue done");
  endtask : t_queue

  // mid-run reset clears the sticky lost flags and the record
  task t_reset;
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk("lost", 32'h0, 32'(lost));
    chk("irq", 32'h0, 32'(irq));
    chk("record", 32'h0, record);
    sys_rst_i <= 1'b0;
    exp_n = 0;
    hit(2'h2);
    get(32'h00010105);
    $display("test reset done");
  endtask : t_reset

  task summarize;
    $display("checks %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  initial begin
    sys_rst_i = 1'b1;
    id_alt    = 1'b0;
    slow      = 1'b0;
    for (int c = 0; c < CHAN_COUNT; c++) begin
      cfg[c] = '{32'sh0, 32'sh5, 32'sh0, 32'sha, MODE_COUNT, 1'b1};
    end
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_basic();
    t_block();
    t_queue();
    t_reset();
    summarize();
  end

  // the tests need well under a thousand cycles
  initial begin
    #(8 * 3000);
    error_cnt++;
    summarize();
  end
endmodule : cmp_irq_record_tb
